// file: logic/flrc_pkg.sv
package flrc_pkg;
  // opcodes
  localparam logic [7:0] OP_UNLOCK = 8'h39;
  localparam logic [7:0] OP_RDLOCK = 8'h3D;
  localparam logic [7:0] OP_GLOCK = 8'h7E;
  localparam logic [7:0] OP_GUNLOCK = 8'h98;
  localparam logic [7:0] OP_RST_EN = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;
  localparam logic [7:0] OP_CNTR = 8'h9B;
  localparam logic [7:0] OP_CNTR_STAT = 8'h96;
  // counter command types
  localparam logic [7:0] CT_ROOT = 8'h00;
  localparam logic [7:0] CT_HKEY = 8'h01;
  localparam logic [7:0] CT_INCR = 8'h02;
  // frame byte counts, opcode included
  localparam logic [7:0] LEN_ROOT = 8'h40;
  localparam logic [7:0] LEN_KEYCMD = 8'h28;
  localparam logic [7:0] LEN_SINGLE = 8'h01;
  localparam logic [7:0] LEN_ADDR3 = 8'h04;
  localparam logic [7:0] LEN_ADDR4 = 8'h05;
  // captured frame: byte n has its msb at FRAME_BITS-1-8n
  localparam int FRAME_BITS = 512;
  localparam int POS_OPC = 511;
  localparam int POS_FADDR = 503;
  localparam int POS_HDR = 503;
  localparam int POS_CADDR = 495;
  localparam int POS_DATA = 479;
  localparam int POS_SIG = 447;
  localparam int POS_RKSIG = 223;
  localparam int HDR_BITS = 24;
  localparam int KEY_BITS = 256;
  localparam int RKSIG_BITS = 224;
  localparam int LOCK_SHIFT = 16;
  // read-back start points, in serial bits
  localparam logic [9:0] RD_START_3B = 10'h020;
  localparam logic [9:0] RD_START_4B = 10'h028;
  localparam logic [9:0] STAT_START = 10'h010;
  localparam logic [6:0] STAT_BYTE_IDX = 7'h02;
  localparam logic [9:0] BIT_CNT_MAX = 10'h3FF;
  // counter status bits
  localparam int STB_BUSY = 0;
  localparam int STB_SIG = 1;
  localparam int STB_PARAM = 2;
  localparam int STB_INIT = 3;
  localparam int STB_CNT = 4;
  localparam int STB_OK = 7;
  localparam logic [7:0] STATUS_RST = 8'h00;
  // timing
  localparam int T_RST_NS = 30000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int HMAC_CYC_DEF = 64;

  typedef enum {S_IDLE, S_CHECK, S_HASH1, S_HASH2, S_COMMIT, S_FINAL,
    S_RECOVER} flrc_state_t;

  typedef struct packed {
    logic [7:0] ctype;
    logic [7:0] caddr;
    logic [7:0] len;
  } flrc_hdr_t;
endpackage

// file: logic/flrc_core.sv
// Function
// - lock bits apply only when scheme select set
// - lock bits volatile, all set on reset
// - opcode 39h plus address clears one lock
// - 3Dh shifts lock byte out, lsb locked
// - 7Eh sets every lock bit
// - 98h clears every lock bit
// - 66h arms, 99h resets, other disarms
// - accepted reset aborts work, restores defaults
// - 30 us recovery rejects all commands; 3Dh and 96h reads still answered
// - root key write needs 64-byte frame
// - root write checks range, uninit, 224-bit signature
// - root init state written last, status ok
// - all-ones root key only initialises counter
// - after real root key, refuse further writes
// - key update: 40 bytes, checks, stores key
// - key update busy spans two hash runs
// - failed check: no execution, error posted
// - increment only after all checks pass
// - counter update single glitch-safe write
// - reserved command types set status bit two
// - busy status read repeats status byte
`timescale 1ns/1ps
module flrc_hmac
  import flrc_pkg::*;
#(
  parameter int CYCLES = HMAC_CYC_DEF
)(
  input wire logic clk_i, // system clock
  input wire logic arst_n_i, // async reset
  input wire logic start_i, // one-cycle start
  input wire logic [255:0] key_i, // key
  input wire logic [255:0] msg_i, // message
  output logic done_o, // one-cycle done
  output logic [255:0] sig_o // signature
);
  logic [15:0] cnt_q;
  logic run_q;
  // stand-in mixing core; the real digest slots in behind same handshake
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cnt_q <= '0;
      run_q <= 1'b0;
      done_o <= 1'b0;
      sig_o <= '0;
    end
    else
    begin
      done_o <= 1'b0;
      if (start_i)
      begin
        run_q <= 1'b1;
        cnt_q <= 16'(CYCLES);
        sig_o <= key_i ^ msg_i;
      end
      else if (run_q)
      begin
        sig_o <= {sig_o[254:0], sig_o[255]} ^ (key_i + msg_i);
        cnt_q <= cnt_q - 16'h0001;
        if (cnt_q == 16'h0001)
        begin
          run_q <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end
endmodule

module flrc_core
  import flrc_pkg::*;
#(
  parameter int NUM_CNTR = 4,
  parameter int LOCK_IDX_W = 9,
  parameter int HMAC_CYC = HMAC_CYC_DEF
)(
  input wire logic CLK_I, // 50 MHz system clock
  input wire logic ARST_N_I, // async reset, active low
  input wire logic SCLK_I, // serial clock from host
  input wire logic CS_N_I, // chip select, active low
  input wire logic MOSI_I, // serial data in
  output logic MISO_O, // serial data out
  output logic MISO_OE_O, // data out enable
  input wire logic ADDR_4B_I, // 4-byte address mode
  input wire logic PROTECT_SCHEME_SELECT_I, // per-block lock scheme
  input wire logic LEGACY_PROT_I, // bit-based protect decode
  input wire logic [LOCK_IDX_W-1:0] PROT_QUERY_I, // block queried
  output logic BLOCK_PROTECTED_O, // queried block protected
  output logic BUSY_O, // counter command or recovery
  output logic DEV_RESET_O, // recovery, resets volatile state
  output logic [7:0] COUNTER_STATUS_O // counter status
);
  localparam int LOCKS = 2 ** LOCK_IDX_W;
  localparam int RST_CYC = (T_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int AW = $clog2(NUM_CNTR);

  function automatic logic [LOCK_IDX_W-1:0] lock_index(
    input logic [FRAME_BITS-1:0] f, input logic a4);
    logic [31:0] a;
    a = a4 ? f[POS_FADDR -: 32] : {8'h00, f[POS_FADDR -: 24]};
    lock_index = a[LOCK_SHIFT +: LOCK_IDX_W];
  endfunction

  // ---------------- link side, serial clock ----------------
  logic sclk_rst_n;
  logic [9:0] bit_cnt_q;
  logic [FRAME_BITS-1:0] frame_q;
  logic [7:0] nbytes_q;
  logic frag_q;
  logic [LOCKS-1:0] lk_s1_q, lk_s2_q;
  logic [7:0] st_s1_q, st_s2_q;
  logic a4_s1_q, a4_s2_q;
  logic [LOCKS-1:0] lock_q;
  logic [7:0] stat_q;

  // chip select high clears the frame position
  assign sclk_rst_n = ARST_N_I & ~CS_N_I;

  always_ff @(posedge SCLK_I or negedge sclk_rst_n)
  begin
    if (!sclk_rst_n)
      bit_cnt_q <= '0;
    else if (bit_cnt_q != BIT_CNT_MAX)
      bit_cnt_q <= bit_cnt_q + 10'h001;
  end

  // frame kept after select rises; the system side reads it once settled
  always_ff @(posedge SCLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      frame_q <= '0;
      nbytes_q <= '0;
      frag_q <= 1'b0;
    end
    else
    begin
      if (bit_cnt_q < 10'(FRAME_BITS))
        frame_q[9'(FRAME_BITS - 1) - bit_cnt_q[8:0]] <= MOSI_I;
      if (bit_cnt_q[2:0] == 3'h7)
        nbytes_q <= {1'b0, bit_cnt_q[9:3]} + 8'h01;
      else if (bit_cnt_q == 10'h000)
        nbytes_q <= '0;
      frag_q <= (bit_cnt_q[2:0] != 3'h7);
    end
  end

  // quasi-static state brought over for read-back, two stages each
  always_ff @(posedge SCLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      lk_s1_q <= '1;
      lk_s2_q <= '1;
      st_s1_q <= STATUS_RST;
      st_s2_q <= STATUS_RST;
      a4_s1_q <= 1'b0;
      a4_s2_q <= 1'b0;
    end
    else
    begin
      lk_s1_q <= lock_q;
      lk_s2_q <= lk_s1_q;
      st_s1_q <= stat_q;
      st_s2_q <= st_s1_q;
      a4_s1_q <= ADDR_4B_I;
      a4_s2_q <= a4_s1_q;
    end
  end

  // read-back on falling edges, msb first
  always_ff @(negedge SCLK_I or negedge sclk_rst_n)
  begin
    if (!sclk_rst_n)
    begin
      MISO_O <= 1'b0;
      MISO_OE_O <= 1'b0;
    end
    else if (frame_q[POS_OPC -: 8] == OP_RDLOCK && bit_cnt_q >=
      (a4_s2_q ? RD_START_4B : RD_START_3B))
    begin
      MISO_OE_O <= 1'b1;
      // only lsb carries the lock state
      MISO_O <= (bit_cnt_q[2:0] == 3'h7) &
        lk_s2_q[lock_index(frame_q, a4_s2_q)];
    end
    else if (frame_q[POS_OPC -: 8] == OP_CNTR_STAT &&
      bit_cnt_q >= STAT_START)
    begin
      MISO_OE_O <= 1'b1;
      // payload fields not produced here; busy repeats the status byte
      if (bit_cnt_q[9:3] == STAT_BYTE_IDX || st_s2_q[STB_BUSY])
        MISO_O <= st_s2_q[3'h7 - bit_cnt_q[2:0]];
      else
        MISO_O <= 1'b0;
    end
  end

  // ---------------- system side ----------------
  logic cs_s1_q, cs_s2_q, cs_s3_q;
  logic frame_end, take, len_addr_ok;
  logic [7:0] opc;
  logic [LOCK_IDX_W-1:0] unlock_idx;
  logic arm_q, rst_go, dev_rst_q;
  logic [15:0] rst_cnt_q;
  flrc_state_t state_q;
  flrc_hdr_t hdr_q;
  logic [FRAME_BITS-1:0] pay_q;
  logic [255:0] root_key_q [NUM_CNTR];
  logic [255:0] hkey_q [NUM_CNTR];
  logic [31:0] cnt_q [NUM_CNTR];
  logic [NUM_CNTR-1:0] rk_uninit_q, mc_init_q, hk_init_q;
  logic [255:0] newkey_q, hkey_in, hmsg_in, hsig, rx_root;
  logic hstart_q, hdone;
  logic [AW-1:0] ai;
  logic [31:0] cnt_sel;
  logic [7:0] chk_err;
  logic prot_q, busy_q;

  // select edge crosses through two stages before use
  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
    end
    else
    begin
      cs_s1_q <= CS_N_I;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
    end
  end

  // whole bytes only; nothing is taken during recovery
  assign frame_end = cs_s2_q & ~cs_s3_q;
  assign take = frame_end & ~frag_q & (state_q != S_RECOVER);
  assign opc = frame_q[POS_OPC -: 8];
  assign unlock_idx = lock_index(frame_q, ADDR_4B_I);
  assign len_addr_ok = nbytes_q == (ADDR_4B_I ? LEN_ADDR4 : LEN_ADDR3);

  // lock array, all set after power-up or accepted reset
  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      lock_q <= '1;
    else if (rst_go)
      lock_q <= '1;
    else if (take && opc == OP_UNLOCK && len_addr_ok)
      lock_q[unlock_idx] <= 1'b0;
    else if (take && opc == OP_GLOCK && nbytes_q == LEN_SINGLE)
      lock_q <= '1;
    else if (take && opc == OP_GUNLOCK && nbytes_q == LEN_SINGLE)
      lock_q <= '0;
  end

  // locks count only under the per-block scheme
  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      prot_q <= 1'b1;
    else
      prot_q <= PROTECT_SCHEME_SELECT_I ? lock_q[PROT_QUERY_I] :
        LEGACY_PROT_I;
  end
  assign BLOCK_PROTECTED_O = prot_q;

  // reset arming: any other accepted frame drops it
  assign rst_go = take & (opc == OP_RST) & arm_q & (nbytes_q == LEN_SINGLE);
  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      arm_q <= 1'b0;
    else if (take)
      arm_q <= (opc == OP_RST_EN) && (nbytes_q == LEN_SINGLE);
  end

  // check outcome of a newly latched counter command
  assign ai = hdr_q.caddr[AW-1:0];
  assign cnt_sel = cnt_q[ai];
  assign rx_root = pay_q[POS_DATA -: KEY_BITS];
  always_comb
  begin
    chk_err = '0;
    if (hdr_q.caddr >= 8'(NUM_CNTR))
      chk_err[STB_PARAM] = 1'b1;
    case (hdr_q.ctype)
      CT_ROOT:
      begin
        chk_err[STB_PARAM] |= hdr_q.len != LEN_ROOT;
        chk_err[STB_INIT] = ~rk_uninit_q[ai];
      end
      CT_HKEY:
      begin
        chk_err[STB_PARAM] |= hdr_q.len != LEN_KEYCMD;
        chk_err[STB_INIT] = ~mc_init_q[ai];
      end
      CT_INCR:
      begin
        chk_err[STB_PARAM] |= hdr_q.len != LEN_KEYCMD;
        chk_err[STB_INIT] = ~mc_init_q[ai] | ~hk_init_q[ai];
      end
      default: chk_err[STB_PARAM] = 1'b1;
    endcase
  end

  // signature engine inputs per command and pass
  always_comb
  begin
    hmsg_in = {pay_q[POS_HDR -: HDR_BITS], pay_q[POS_DATA -: 32], 200'h0};
    case (hdr_q.ctype)
      CT_ROOT: hkey_in = rx_root;
      CT_HKEY:
      begin
        hkey_in = (state_q == S_HASH2) ? newkey_q : root_key_q[ai];
        if (state_q != S_HASH2)
          hmsg_in = {pay_q[POS_DATA -: 32], 224'h0};
      end
      default: hkey_in = hkey_q[ai];
    endcase
  end

  flrc_hmac #(.CYCLES(HMAC_CYC)) u_hmac (
    .clk_i(CLK_I),
    .arst_n_i(ARST_N_I),
    .start_i(hstart_q),
    .key_i(hkey_in),
    .msg_i(hmsg_in),
    .done_o(hdone),
    .sig_o(hsig)
  );

  // command sequencer; an accepted reset aborts whatever runs
  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      state_q <= S_IDLE;
      stat_q <= STATUS_RST;
      hdr_q <= '0;
      pay_q <= '0;
      hstart_q <= 1'b0;
      newkey_q <= '0;
      rst_cnt_q <= '0;
      dev_rst_q <= 1'b0;
    end
    else
    begin
      hstart_q <= 1'b0;
      if (rst_go)
      begin
        state_q <= S_RECOVER;
        stat_q <= STATUS_RST;
        rst_cnt_q <= 16'(RST_CYC);
        dev_rst_q <= 1'b1;
      end
      else
        case (state_q)
          S_IDLE:
            if (take && opc == OP_CNTR)
            begin
              pay_q <= frame_q;
              hdr_q <= '{frame_q[POS_HDR -: 8], frame_q[POS_CADDR -: 8],
                nbytes_q};
              stat_q <= 8'h01 << STB_BUSY;
              state_q <= S_CHECK;
            end
          S_CHECK:
            if (chk_err != '0)
            begin
              stat_q <= chk_err;
              state_q <= S_IDLE;
            end
            else
            begin
              hstart_q <= 1'b1;
              state_q <= S_HASH1;
            end
          S_HASH1:
            if (hdone)
            begin
              if (hdr_q.ctype == CT_HKEY)
              begin
                newkey_q <= hsig; // second pass doubles busy time
                hstart_q <= 1'b1;
                state_q <= S_HASH2;
              end
              else if (hdr_q.ctype == CT_ROOT ?
                hsig[RKSIG_BITS-1:0] != pay_q[POS_RKSIG -: RKSIG_BITS] :
                hsig != pay_q[POS_SIG -: KEY_BITS])
              begin
                stat_q <= 8'h01 << STB_SIG;
                state_q <= S_IDLE;
              end
              else if (hdr_q.ctype == CT_INCR &&
                pay_q[POS_DATA -: 32] != cnt_sel)
              begin
                stat_q <= 8'h01 << STB_CNT;
                state_q <= S_IDLE;
              end
              else
                state_q <= S_COMMIT;
            end
          S_HASH2:
            if (hdone)
            begin
              if (hsig != pay_q[POS_SIG -: KEY_BITS])
              begin
                stat_q <= 8'h01 << STB_SIG;
                state_q <= S_IDLE;
              end
              else
                state_q <= S_COMMIT;
            end
          S_COMMIT: state_q <= S_FINAL;
          S_FINAL:
          begin
            stat_q <= 8'h01 << STB_OK;
            state_q <= S_IDLE;
          end
          S_RECOVER:
          begin
            rst_cnt_q <= rst_cnt_q - 16'h0001;
            if (rst_cnt_q == 16'h0001)
            begin
              dev_rst_q <= 1'b0;
              state_q <= S_IDLE;
            end
          end
          default: state_q <= S_IDLE;
        endcase
    end
  end

  // per-address stores; root key is never routed to the serial output
  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      for (int i = 0; i < NUM_CNTR; i++)
      begin
        root_key_q[i] <= '0;
        hkey_q[i] <= '0;
        cnt_q[i] <= '0;
      end
      rk_uninit_q <= '1;
      mc_init_q <= '0;
      hk_init_q <= '0;
    end
    else if (rst_go)
      hk_init_q <= '0;
    else if (state_q == S_COMMIT)
    begin
      case (hdr_q.ctype)
        CT_ROOT:
        begin
          if (rx_root != '1)
            root_key_q[ai] <= rx_root;
          if (!mc_init_q[ai])
          begin
            cnt_q[ai] <= '0;
            mc_init_q[ai] <= 1'b1;
          end
        end
        CT_HKEY:
        begin
          hkey_q[ai] <= newkey_q;
          hk_init_q[ai] <= 1'b1;
        end
        // whole word in one write: never half-updated
        default: cnt_q[ai] <= cnt_sel + 32'h0000_0001;
      endcase
    end
    else if (state_q == S_FINAL && hdr_q.ctype == CT_ROOT &&
      rx_root != '1)
      rk_uninit_q[ai] <= 1'b0;
  end

  // busy registered so the pin comes straight from a flop; lags one cycle
  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      busy_q <= 1'b0;
    else
      busy_q <= stat_q[STB_BUSY] | dev_rst_q;
  end
  assign BUSY_O = busy_q;
  assign DEV_RESET_O = dev_rst_q;
  assign COUNTER_STATUS_O = stat_q;

  // ---------------- checks ----------------
  chk_unlock_one: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    take && opc == OP_UNLOCK && len_addr_ok && !rst_go
    |=> !lock_q[$past(unlock_idx)])
    else $error("unlock missed addressed block");
  chk_recover_locks: assert property (@(posedge CLK_I)
    disable iff (!ARST_N_I) rst_go |=> ((&lock_q) && dev_rst_q) [*8])
    else $error("locks not set during recovery");
  chk_global_lock: assert property (@(posedge CLK_I)
    disable iff (!ARST_N_I)
    take && opc == OP_GLOCK && nbytes_q == LEN_SINGLE |=> &lock_q)
    else $error("global lock incomplete");
  chk_global_unlock: assert property (@(posedge CLK_I)
    disable iff (!ARST_N_I) take && opc == OP_GUNLOCK &&
    nbytes_q == LEN_SINGLE && !rst_go |=> lock_q == '0)
    else $error("global unlock incomplete");
  chk_arm_drop: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    take && opc != OP_RST_EN |=> !arm_q ##1 !rst_go)
    else $error("reset stayed armed");
  chk_prot_scheme: assert property (@(posedge CLK_I)
    disable iff (!ARST_N_I) !PROTECT_SCHEME_SELECT_I
    |=> BLOCK_PROTECTED_O == $past(LEGACY_PROT_I))
    else $error("locks used without scheme select");
  chk_reserved_type: assert property (@(posedge CLK_I)
    disable iff (!ARST_N_I) state_q == S_CHECK && hdr_q.ctype > CT_INCR
    && !rst_go |=> stat_q[STB_PARAM] && state_q == S_IDLE)
    else $error("reserved type not flagged");
  chk_incr_one: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    state_q == S_COMMIT && hdr_q.ctype == CT_INCR && !rst_go
    |=> cnt_sel == $past(cnt_sel) + 32'h0000_0001 ##1 stat_q[STB_OK])
    else $error("counter not incremented by one");
  chk_key_busy: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    state_q == S_HASH1 && hdone && hdr_q.ctype == CT_HKEY && !rst_go
    |=> state_q == S_HASH2 && BUSY_O)
    else $error("key update skipped second pass");
endmodule

// file: verification/flrc_host.sv
`timescale 1ns/1ps
// host flash controller, serial clock of 6 ns, still between frames
module flrc_host (
  output logic sclk_o, // serial clock
  output logic cs_n_o, // chip select, active low
  output logic mosi_o, // serial data to device
  input wire logic miso_i // serial data from device
);
  // idle: deselected, clock low
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // single clock pulse so the serial side sees its reset
  task automatic tick();
    #3 sclk_o = 1'b1;
    #3 sclk_o = 1'b0;
  endtask

  // whole bytes, msb first; rx keeps the last byte seen on the data line
  task automatic xfer(input logic [511:0] f, input int nbytes,
    output logic [7:0] rx);
    rx = 8'h00;
    cs_n_o = 1'b0;
    for (int i = 0; i < 8 * nbytes; i++)
    begin
      mosi_o = f[511 - i];
      #3 sclk_o = 1'b1;
      rx = {rx[6:0], miso_i};
      #3 sclk_o = 1'b0;
    end
    #3 cs_n_o = 1'b1;
    mosi_o = ~mosi_o; // line inverted after the frame, not held at the last bit
  endtask
endmodule

// file: verification/tb_flrc_core.sv
`timescale 1ns/1ps
module tb_flrc_core;
  import flrc_pkg::*;
  localparam int HC = 40;
  logic clk, arst_n, sclk, cs_n, mosi, miso, miso_oe, addr_4b;
  logic scheme, legacy, prot, busy, dev_rst;
  logic [8:0] query;
  logic [7:0] status, rx;
  logic [255:0] rk, nk;
  int bad_count, check_count, ncyc, nu;
  logic oe_seen;

  flrc_core #(.HMAC_CYC(HC)) u_flrc_core (.CLK_I(clk), .ARST_N_I(arst_n),
    .SCLK_I(sclk), .CS_N_I(cs_n), .MOSI_I(mosi), .MISO_O(miso),
    .MISO_OE_O(miso_oe), .ADDR_4B_I(addr_4b),
    .PROTECT_SCHEME_SELECT_I(scheme), .LEGACY_PROT_I(legacy),
    .PROT_QUERY_I(query), .BLOCK_PROTECTED_O(prot), .BUSY_O(busy),
    .DEV_RESET_O(dev_rst), .COUNTER_STATUS_O(status));
  flrc_host u_flrc_host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
    .miso_i(miso));

  // output enable as seen at the last serial rise of each frame
  always @(posedge sclk)
    oe_seen <= miso_oe;

  // 50 MHz system clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic print_verdict();
    if (bad_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmp(input logic [7:0] got, exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // inputs move a little after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // stand-in signature engine, kept apart from the design's copy
  function automatic logic [255:0] mix(input logic [255:0] k, m);
    logic [255:0] s;
    s = k ^ m;
    for (int i = 0; i < HC; i++)
      s = {s[254:0], s[255]} ^ (k + m);
    return s;
  endfunction

  // right-aligned frame of n bytes; counter frames wait out busy
  task automatic send(input logic [511:0] x, input int n);
    u_flrc_host.xfer(x << (512 - 8 * n), n, rx);
    ncyc = 0;
    step(6);
    while (n > 5 && busy === 1'b1 && ncyc < 300)
    begin
      step(1);
      ncyc++;
    end
  endtask

  task automatic prot_is(input logic [7:0] b, input logic e);
    query = {1'b0, b};
    step(2);
    cmp({7'h0, prot}, {7'h0, e}, "protect");
  endtask

  task automatic lock_rd(input logic [7:0] b, e);
    send({OP_RDLOCK, b, 16'h0000, 8'h00}, 5);
    cmp(rx, e, "lock read");
    cmp({7'h0, oe_seen}, 8'h01, "lock read enable");
  endtask

  task automatic root_wr(input logic [7:0] a, input logic [255:0] k,
    input int n);
    logic [255:0] s;
    s = mix(k, {CT_ROOT, a, 8'h00, k[255:224], 200'h0});
    send({OP_CNTR, CT_ROOT, a, 8'h00, k, s[223:0]} >> (512 - 8 * n),
      n);
  endtask

  task automatic kcmd(input logic [7:0] t, a, input logic [31:0] d,
    input logic [255:0] k, input logic bad);
    logic [255:0] s;
    s = mix(k, {t, a, 8'h00, d, 200'h0});
    s[0] = s[0] ^ bad;
    send({OP_CNTR, t, a, 8'h00, d, s}, 40);
  endtask

  task automatic t_scheme();
    prot_is(8'h03, 1'b1);
    scheme = 1'b0;
    prot_is(8'h03, 1'b0);
    legacy = 1'b1;
    prot_is(8'h03, 1'b1);
    scheme = 1'b1;
    legacy = 1'b0;
  endtask

  task automatic t_locks();
    send({OP_UNLOCK, 8'h05, 16'h0000}, 4);
    prot_is(8'h05, 1'b0);
    prot_is(8'h06, 1'b1);
    lock_rd(8'h05, 8'h00);
    lock_rd(8'h06, 8'h01);
    send({OP_UNLOCK, 8'h07, 8'h00}, 3);
    prot_is(8'h07, 1'b1);
    addr_4b = 1'b1;
    send({OP_UNLOCK, 8'h00, 8'h06, 16'h0000}, 5);
    prot_is(8'h06, 1'b0);
    addr_4b = 1'b0;
    send({OP_GUNLOCK}, 1);
    prot_is(8'h09, 1'b0);
    send({OP_GLOCK, 8'h00}, 2);
    prot_is(8'h09, 1'b0);
    send({OP_GLOCK}, 1);
    prot_is(8'h05, 1'b1);
    cmp({7'h0, oe_seen}, 8'h00, "no drive on write");
  endtask

  task automatic t_swreset();
    int k;
    send({OP_GUNLOCK}, 1);
    cmp({7'h0, busy}, 8'h00, "idle before reset");
    send({OP_RST_EN}, 1);
    send({OP_GUNLOCK}, 1);
    send({OP_RST}, 1);
    cmp({7'h0, dev_rst}, 8'h00, "disarmed");
    send({OP_RST_EN}, 1);
    send({OP_RST}, 1);
    cmp({7'h0, dev_rst}, 8'h01, "reset taken");
    cmp({7'h0, busy}, 8'h01, "recovery busy");
    prot_is(8'h09, 1'b1);
    send({OP_GUNLOCK}, 1);
    prot_is(8'h09, 1'b1);
    k = 0;
    while (dev_rst === 1'b1 && k < 1600)
    begin
      step(1);
      k++;
    end
    cmp({7'h0, k > 1400 && k < 1500}, 8'h01, "recovery span");
  endtask

  task automatic t_counter();
    logic [255:0] s;
    rk = {8{32'h1234_5678}};
    root_wr(8'h01, '1, 64);
    cmp(status, 8'h80, "root ones");
    root_wr(8'h01, rk, 64);
    cmp(status, 8'h80, "root key");
    root_wr(8'h01, rk, 64);
    cmp(status & 8'h88, 8'h08, "root again");
    root_wr(8'h04, rk, 64);
    cmp(status & 8'h84, 8'h04, "root range");
    root_wr(8'h02, rk, 40);
    cmp(status & 8'h84, 8'h04, "root length");
    nk = mix(rk, {32'hCAFE_0001, 224'h0});
    kcmd(CT_HKEY, 8'h01, 32'hCAFE_0001, nk, 1'b0);
    nu = ncyc;
    cmp(status, 8'h80, "key update");
    kcmd(CT_HKEY, 8'h02, 32'h0000_0000, nk, 1'b0);
    cmp(status & 8'h88, 8'h08, "key uninit");
    kcmd(CT_INCR, 8'h01, 32'h0000_0000, nk, 1'b0);
    cmp(status, 8'h80, "increment");
    cmp({7'h0, nu >= ncyc + HC}, 8'h01, "two hash spans");
    kcmd(CT_INCR, 8'h01, 32'h0000_0000, nk, 1'b0);
    cmp(status & 8'h90, 8'h10, "stale count");
    kcmd(CT_INCR, 8'h01, 32'h0000_0001, nk, 1'b1);
    cmp(status & 8'h82, 8'h02, "bad signature");
    kcmd(CT_INCR, 8'h01, 32'h0000_0001, nk, 1'b0);
    cmp(status, 8'h80, "second increment");
    // status read while the third increment is still hashing
    s = mix(nk, {CT_INCR, 8'h01, 8'h00, 32'h0000_0002, 200'h0});
    u_flrc_host.xfer({OP_CNTR, CT_INCR, 8'h01, 8'h00, 32'h0000_0002, s,
      192'h0}, 40, rx);
    step(5);
    send({OP_CNTR_STAT, 24'h00_0000}, 4);
    cmp(rx, 8'h01, "busy status repeat");
    ncyc = 0;
    while (busy === 1'b1 && ncyc < 300)
    begin
      step(1);
      ncyc++;
    end
    cmp(status, 8'h80, "third increment");
    send({OP_CNTR_STAT, 16'h0000}, 3);
    cmp(rx, 8'h80, "status byte");
    send({OP_CNTR_STAT, 24'h00_0000}, 4);
    cmp(rx, 8'h00, "idle payload");
    cmp({7'h0, oe_seen}, 8'h01, "status enable");
    kcmd(8'h04, 8'h01, 32'h0000_0003, nk, 1'b0);
    cmp(status & 8'h84, 8'h04, "type 04");
    kcmd(8'hFF, 8'h01, 32'h0000_0003, nk, 1'b0);
    cmp(status & 8'h84, 8'h04, "type ff");
  endtask

  // hang guard, well past the expected run
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    print_verdict();
  end

  // reset, then the scenarios in order
  initial
  begin
    arst_n = 1'b0;
    addr_4b = 1'b0;
    scheme = 1'b1;
    legacy = 1'b0;
    query = 9'h000;
    bad_count = 0;
    check_count = 0;
    step(2);
    u_flrc_host.tick();
    step(14);
    arst_n = 1'b1;
    step(4);
    t_scheme();
    t_locks();
    t_swreset();
    t_counter();
    print_verdict();
  end
endmodule
